// [rdseq_counter.v]
// Down counter for one delay interval
`timescale 1ns/1ns
`default_nettype none
module rdseq_counter (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        load,
  input  wire [22:0] load_val,
  input  wire        tick,
  output wire        done
);
  reg [22:0] cnt_r;
  reg        run_r;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_r <= 23'h0;
      run_r <= 1'b0;
    end else if (load) begin
      cnt_r <= load_val;
      run_r <= 1'b1;
    end else if (run_r && tick) begin
      if (cnt_r <= 23'h1)
        run_r <= 1'b0;
      cnt_r <= cnt_r - 23'h1;
    end
  end

  // Done ignores load: the caller decodes load from done
  assign done = !run_r;
endmodule // rdseq_counter
`default_nettype wire

// [rdseq_defines.vh]
// Timing constants and field codes of the reset delay sequencer
`ifndef RDSEQ_DEFINES_VH
`define RDSEQ_DEFINES_VH

`define RDSEQ_CLK_MHZ         100
// Times in microseconds, as printed
`define RDSEQ_T_POR_US        10
`define RDSEQ_T_VREG_US       10
`define RDSEQ_T_PWRT_US       64000
`define RDSEQ_T_RST_US        20
`define RDSEQ_T_FAIL_SAFE_CLOCK_MONITOR_US       100
// Cycle counts at the clock rate, sized for the 23-bit delay counter, then the crystal start-up count in oscillator periods
`define RDSEQ_POR_CYC         23'd1000
`define RDSEQ_VREG_CYC        23'd1000
`define RDSEQ_PWRT_CYC        23'd6400000
`define RDSEQ_RST_CYC         23'd2000
`define RDSEQ_FAIL_SAFE_CLOCK_MONITOR_CYC        23'd10000
`define RDSEQ_OST_PERIODS     1024

// Clock source codes of the oscillator config word
`define RDSEQ_SRC_EC          3'h0
`define RDSEQ_SRC_FRC         3'h1
`define RDSEQ_SRC_FRCDIV      3'h2
`define RDSEQ_SRC_LOW_POWER_INTERNAL_OSCILLATOR        3'h3
`define RDSEQ_SRC_ECPLL       3'h4
`define RDSEQ_SRC_FRCPLL      3'h5
`define RDSEQ_SRC_XT          3'h6
`define RDSEQ_SRC_XTPLL       3'h7
// Extra bit: crystal/secondary path also flagged by src_is_secondary_oscillator input

// Reset cause bit positions
`define RDSEQ_CAUSE_POR       0
`define RDSEQ_CAUSE_BOR       1
`define RDSEQ_CAUSE_EXT       2
`define RDSEQ_CAUSE_WDT       3
`define RDSEQ_CAUSE_SW        4
`define RDSEQ_CAUSE_IOP       5
`define RDSEQ_CAUSE_UWR       6
`define RDSEQ_CAUSE_TRAP      7
`define RDSEQ_CAUSE_W         8

// Oscillator control register reset fields
`define RDSEQ_OSC_CUR_LSB     0
`define RDSEQ_OSC_NEW_LSB     3
`define RDSEQ_OSC_FAIL_BIT    6
`define RDSEQ_OSC_W           7

`endif

// [rdseq_osc_model.sv]
// Crystal oscillator and PLL model feeding the sequencer
`timescale 1ns/1ns
`default_nettype none
module rdseq_osc_model (
  input  wire  core_clk,
  input  wire  dead,
  output logic osc_tick,
  output logic pll_locked,
  output wire  clock_valid
);
  logic [7:0] cnt_r = 8'h00;
  initial osc_tick = 1'b0;
  initial pll_locked = 1'b0;
  assign clock_valid = !dead;
  // Dead crystal gives no ticks and never locks
  always @(posedge core_clk) begin
    cnt_r <= dead ? 8'h00 : cnt_r + 8'h01;
    osc_tick <= !dead && cnt_r[1:0] == 2'h3;
    pll_locked <= !dead && (pll_locked || cnt_r == 8'hff);
  end
endmodule // rdseq_osc_model
`default_nettype wire

// [rdseq_sequencer.v]
// Reset release sequencer with clock release and fail-safe monitor start
`timescale 1ns/1ns
`default_nettype none
`include "rdseq_defines.vh"

// Functional notes
// - POR adds power-on delay; BOR skips it
// - Startup delay: regulator or power-up timer
// - Other resets hold only internal reset time
// - Crystal sources wait 1024 oscillator periods
// - PLL sources also wait for lock
// - Reset release independent of oscillator state
// - No fetch until valid clock released
// - Monitor starts at release, falls back fast
// - Monitor delay 100 us for crystal/PLL
// - Other register reset values type independent
// - Cause register records reset type
// - Oscillator register from type and config; code loads both fields from the config word for every type
// - RTC cal and NVM reset only on POR
module rdseq_sequencer #(
  parameter [22:0] PWRT_CYC = `RDSEQ_PWRT_CYC
) (
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire       req_por,
  input  wire       req_bor,
  input  wire       req_ext,
  input  wire       req_wdt,
  input  wire       req_sw,
  input  wire       req_iop,
  input  wire       req_uwr,
  input  wire       req_trap,
  input  wire       regulator_en,
  input  wire [2:0] oscillator_config_word,
  input  wire       src_is_secondary_oscillator,
  input  wire       fail_safe_clock_monitor_en,
  input  wire       osc_tick,
  input  wire       pll_locked,
  input  wire       clock_valid,
  output reg        internal_system_reset,
  output reg        clock_released,
  output reg        cpu_run,
  output reg        fail_safe_active,
  output reg        fallback_to_fast_osc,
  output reg        osc_fail_trap,
  output reg  [7:0] reset_cause_register,
  output reg  [6:0] oscillator_control_register,
  output reg        rtc_cal_reset,
  output reg        nvm_ctl_reset,
  output reg        periph_reset
);
  localparam [5:0] ST_POR  = 6'h01;
  localparam [5:0] ST_STUP = 6'h02;
  localparam [5:0] ST_RST  = 6'h04;
  localparam [5:0] ST_RUN  = 6'h08;
  localparam [5:0] ST_IDLE = 6'h10;
  localparam [5:0] ST_FSD  = 6'h20;

  function is_pll;
    input [2:0] s;
    is_pll = (s == `RDSEQ_SRC_ECPLL) || (s == `RDSEQ_SRC_FRCPLL) ||
             (s == `RDSEQ_SRC_XTPLL);
  endfunction

  function is_xtal;
    input [2:0] s;
    input       secondary_oscillator;
    is_xtal = secondary_oscillator || (s == `RDSEQ_SRC_XT) || (s == `RDSEQ_SRC_XTPLL);
  endfunction

  wire [7:0] req_vec = {req_trap, req_uwr, req_iop, req_sw,
                        req_wdt, req_ext, req_bor, req_por};
  wire       any_req = |req_vec;

  reg [5:0]  st_r;
  reg        mon_st_r;
  reg        seq_load;
  reg [22:0] seq_val;
  wire       seq_done;
  reg [2:0]  src_r;
  reg        secondary_oscillator_r;
  // Leaving rst_n counts as a power-on request for one cycle
  reg        por_pend_r;

  rdseq_counter u_seq (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .load     (seq_load),
    .load_val (seq_val),
    .tick     (1'b1),
    .done     (seq_done)
  );

  // Oscillator start-up counter runs on oscillator periods, restarts on any request
  reg [9:0] ost_r;
  reg       ost_done_r;
  always @(posedge core_clk) begin
    if (!rst_n || any_req) begin
      ost_r      <= 10'h0;
      ost_done_r <= 1'b0;
    end else if (!ost_done_r && osc_tick) begin
      ost_r <= ost_r + 10'h1;
      if (ost_r == 10'h3ff)
        ost_done_r <= 1'b1;
    end
  end

  wire xtal_ok = !is_xtal(src_r, secondary_oscillator_r) || ost_done_r;
  wire pll_ok  = !is_pll(src_r) || pll_locked;
  wire clk_ok  = xtal_ok && pll_ok;
  wire needs_fail_safe_clock_monitor = is_xtal(src_r, secondary_oscillator_r) || is_pll(src_r);

  wire [22:0] stup_cyc = regulator_en ? `RDSEQ_VREG_CYC : PWRT_CYC;

  always @* begin
    seq_load = 1'b0;
    seq_val  = 23'h0;
    if (req_por || por_pend_r) begin
      seq_load = 1'b1;
      seq_val  = `RDSEQ_POR_CYC;
    end else if (req_bor) begin
      seq_load = 1'b1;
      seq_val  = stup_cyc;
    end else if (any_req) begin
      seq_load = 1'b1;
      seq_val  = `RDSEQ_RST_CYC;
    end else if (seq_done) begin
      case (st_r)
        ST_POR: begin
          seq_load = 1'b1;
          seq_val  = stup_cyc;
        end
        ST_STUP: begin
          seq_load = 1'b1;
          seq_val  = `RDSEQ_RST_CYC;
        end
        ST_RUN: begin
          if (mon_st_r && needs_fail_safe_clock_monitor) begin
            seq_load = 1'b1;
            seq_val  = `RDSEQ_FAIL_SAFE_CLOCK_MONITOR_CYC;
          end
        end
        default: begin
          seq_load = 1'b0;
          seq_val  = 23'h0;
        end
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      st_r     <= ST_POR;
      mon_st_r <= 1'b0;
      src_r    <= `RDSEQ_SRC_FRC;
      secondary_oscillator_r   <= 1'b0;
      por_pend_r <= 1'b1;
    end else begin
      mon_st_r <= 1'b0;
      por_pend_r <= 1'b0;
      if (req_por || por_pend_r)
        st_r <= ST_POR;
      else if (req_bor)
        st_r <= ST_STUP;
      else if (any_req)
        st_r <= ST_RST;
      else if (seq_done) begin
        case (st_r)
          ST_POR:  st_r <= ST_STUP;
          ST_STUP: st_r <= ST_RST;
          ST_RST: begin
            st_r     <= ST_RUN;
            mon_st_r <= 1'b1;
          end
          ST_RUN:  st_r <= (mon_st_r && needs_fail_safe_clock_monitor) ? ST_FSD : ST_IDLE;
          ST_FSD:  st_r <= ST_IDLE;
          ST_IDLE: st_r <= ST_IDLE;
          default: st_r <= ST_POR;
        endcase
      end
      if (any_req) begin
        src_r  <= oscillator_config_word;
        secondary_oscillator_r <= src_is_secondary_oscillator;
      end
    end
  end

  wire in_reset = (st_r == ST_POR) || (st_r == ST_STUP) ||
                  (st_r == ST_RST) || any_req;
  // Monitor waits out its delay before judging the clock
  wire mon_go = fail_safe_clock_monitor_en && (st_r == ST_IDLE);

  always @(posedge core_clk) begin
    if (!rst_n) begin
      internal_system_reset <= 1'b1;
      clock_released        <= 1'b0;
      cpu_run               <= 1'b0;
      fail_safe_active      <= 1'b0;
      fallback_to_fast_osc  <= 1'b0;
      osc_fail_trap         <= 1'b0;
    end else begin
      internal_system_reset <= in_reset;
      osc_fail_trap         <= 1'b0;
      if (any_req) begin
        clock_released       <= 1'b0;
        fallback_to_fast_osc <= 1'b0;
        fail_safe_active     <= 1'b0;
      end else begin
        if (clk_ok || fallback_to_fast_osc)
          clock_released <= 1'b1;
        fail_safe_active <= mon_go;
        if (mon_go && !clock_valid && !fallback_to_fast_osc) begin
          fallback_to_fast_osc <= 1'b1;
          osc_fail_trap        <= 1'b1;
        end
      end
      cpu_run <= !in_reset && (clock_released || fallback_to_fast_osc)
                 && !any_req;
    end
  end

  // Special reset values; all other registers use periph_reset
  always @(posedge core_clk) begin
    if (!rst_n) begin
      reset_cause_register        <= 8'h01;
      oscillator_control_register <= 7'h00;
      rtc_cal_reset               <= 1'b1;
      nvm_ctl_reset               <= 1'b1;
      periph_reset                <= 1'b1;
    end else begin
      periph_reset  <= any_req;
      rtc_cal_reset <= req_por;
      nvm_ctl_reset <= req_por;
      if (any_req)
        reset_cause_register <= req_vec;
      if (any_req)
        oscillator_control_register <=
          {1'b0, oscillator_config_word, oscillator_config_word};
      else if (fallback_to_fast_osc)
        oscillator_control_register[`RDSEQ_OSC_FAIL_BIT] <= 1'b1;
    end
  end
endmodule // rdseq_sequencer
`default_nettype wire

// [rdseq_sva.sv]
// Port checker of the reset delay sequencer
`timescale 1ns/1ns
`default_nettype none
module rdseq_sva (
  input wire       core_clk,
  input wire       rst_n,
  input wire       req_por,
  input wire       req_bor,
  input wire       req_ext,
  input wire       req_wdt,
  input wire       req_sw,
  input wire       req_iop,
  input wire       req_uwr,
  input wire       req_trap,
  input wire       internal_system_reset,
  input wire       clock_released,
  input wire       cpu_run,
  input wire       fail_safe_active,
  input wire       fallback_to_fast_osc,
  input wire       osc_fail_trap,
  input wire [7:0] reset_cause_register,
  input wire       rtc_cal_reset,
  input wire       periph_reset,
  input wire       nvm_ctl_reset,
  input wire [6:0] oscillator_control_register
);
  wire       any_req;
  reg [11:0] quiet_r;
  assign any_req = req_por | req_bor | req_ext | req_wdt | req_sw | req_iop |
                   req_uwr | req_trap;
  // Cycles since the last request, saturating
  always @(posedge core_clk) begin
    if (!rst_n || any_req)
      quiet_r <= 12'h000;
    else if (quiet_r != 12'hfff)
      quiet_r <= quiet_r + 12'h001;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence seq_req;
    any_req;
  endsequence
  sequence seq_held;
    internal_system_reset [*2];
  endsequence
  AST_REQ_HOLD: assert property (seq_req |=> seq_held)
    else $error("reset not held after request");
  AST_MIN_HOLD: assert property ($fell(internal_system_reset) |->
    quiet_r >= 12'h7cb) else $error("reset released too early");
  AST_CPU_GATE: assert property ((!clock_released) [*2] |-> !cpu_run)
    else $error("cpu runs without clock");
  AST_CPU_RISE: assert property ($rose(cpu_run) |->
    !internal_system_reset) else $error("cpu runs in reset");
  AST_TRAP_PULSE: assert property (osc_fail_trap |=> !osc_fail_trap)
    else $error("trap longer than one cycle");
  AST_TRAP_FB: assert property (osc_fail_trap |->
    ##[0:1] fallback_to_fast_osc) else $error("trap without fallback");
  AST_FB_STICKY: assert property (fallback_to_fast_osc && !any_req |=>
    fallback_to_fast_osc) else $error("fallback dropped");
  AST_MON_START: assert property ($rose(fail_safe_active) |->
    !internal_system_reset) else $error("monitor started in reset");
  AST_CAUSE_EXT: assert property (req_ext && !req_por && !req_bor |=>
    reset_cause_register[2]) else $error("cause misses pin reset");
  AST_RTC_KEEP: assert property (!req_por |=> !rtc_cal_reset)
    else $error("rtc reset without power-on");
  AST_RTC_SET: assert property (req_por |=> rtc_cal_reset)
    else $error("rtc not reset on power-on");
  AST_PERIPH: assert property (seq_req |=> periph_reset)
    else $error("peripherals not reset");
  AST_NVM_KEEP: assert property (!req_por |=> !nvm_ctl_reset)
    else $error("nvm reset without power-on");
  AST_OSC_FAIL: assert property (fallback_to_fast_osc && !any_req |=>
    oscillator_control_register[6]) else $error("fail bit not set");
endmodule // rdseq_sva
bind rdseq_sequencer rdseq_sva rdseq_sva_inst (.*);
`default_nettype wire

// [reset_delay_sequencer_bench.sv]
// Self-checking bench of the reset delay sequencer
`timescale 1ns/1ns
`default_nettype none
`include "rdseq_defines.vh"
module reset_delay_sequencer_bench;
  localparam int PWRT = 50;
  logic core_clk = 1'b0, rst_n = 1'b0, regulator_en = 1'b1;
  logic src_is_secondary_oscillator = 1'b0, fail_safe_clock_monitor_en = 1'b1, dead = 1'b0;
  logic req_por = 1'b0, req_bor = 1'b0, req_ext = 1'b0, req_wdt = 1'b0;
  logic req_sw = 1'b0, req_iop = 1'b0, req_uwr = 1'b0, req_trap = 1'b0;
  logic [2:0] oscillator_config_word = `RDSEQ_SRC_XT;
  wire osc_tick, pll_locked, clock_valid, internal_system_reset;
  wire clock_released, cpu_run, fail_safe_active, fallback_to_fast_osc;
  wire osc_fail_trap, rtc_cal_reset, nvm_ctl_reset, periph_reset;
  wire [7:0] reset_cause_register;
  wire [6:0] oscillator_control_register;
  int n_mismatch = 0, checks = 0, seed = 32'h2653, t, i;
  int q[$];
  always #5 core_clk = ~core_clk;
  rdseq_sequencer #(.PWRT_CYC(23'd50)) rdseq_sequencer_inst (.*);
  rdseq_osc_model rdseq_osc_model_inst (.*);
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (!ok) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      0: return internal_system_reset;
      1: return clock_released;
      default: return fallback_to_fast_osc;
    endcase
  endfunction
  task automatic wait_for(input int sel, input logic v, output int n);
    n = 0;
    while (pick(sel) !== v && n < 30000) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  function automatic int exp_hold(input int k, input logic r);
    return (k == 0 ? `RDSEQ_POR_CYC : 0) + `RDSEQ_RST_CYC +
      (k < 2 ? (r ? `RDSEQ_VREG_CYC : PWRT) : 0);
  endfunction
  task automatic measure(input int k);
    q.push_back(exp_hold(k, regulator_en));
    wait_for(0, 1'b0, t);
    chk(t >= q[0] - 2 && t <= q[0] + 5, "reset hold length");
    chk(reset_cause_register === 8'h01 << k, "reset cause");
    void'(q.pop_front());
    $display("test done, reset kind %0d", k);
  endtask
  task automatic fire(input int k);
    @(negedge core_clk);
    {req_trap, req_uwr, req_iop, req_sw, req_wdt, req_ext, req_bor,
     req_por} = 8'h01 << k;
    @(negedge core_clk);
    {req_trap, req_uwr, req_iop, req_sw, req_wdt, req_ext, req_bor,
     req_por} = 8'h00;
    measure(k);
    chk({1'b0, oscillator_config_word, oscillator_config_word} ===
        oscillator_control_register, "oscillator register");
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    measure(0);
    for (i = 0; i < 8; i++) begin
      oscillator_config_word = $random(seed);
      regulator_en = $random(seed);
      fire(i);
    end
    oscillator_config_word = `RDSEQ_SRC_XTPLL;
    fire(2);
    chk(clock_released === 1'b0, "clock released before count");
    wait_for(1, 1'b1, t);
    chk(t >= 4096 - 2002 - 8 &&
        t <= 4096 - 2002 + 8, "start-up count");
    repeat (2) @(negedge core_clk);
    chk(cpu_run === 1'b1, "cpu not running");
    dead = 1'b1;
    // Crystal waits out the monitor delay, plain clock does not
    oscillator_config_word = `RDSEQ_SRC_XT;
    fire(3);
    chk(clock_released === 1'b0, "dead crystal released");
    wait_for(2, 1'b1, t);
    chk(t >= `RDSEQ_FAIL_SAFE_CLOCK_MONITOR_CYC - 2 &&
        t <= `RDSEQ_FAIL_SAFE_CLOCK_MONITOR_CYC + 5, "monitor delay");
    // Dead oscillator never lets the PLL lock
    oscillator_config_word = `RDSEQ_SRC_ECPLL;
    fire(5);
    chk(clock_released === 1'b0, "released without lock");
    oscillator_config_word = `RDSEQ_SRC_EC;
    fire(4);
    wait_for(2, 1'b1, t);
    chk(t <= 5, "fallback late");
    repeat (3) @(negedge core_clk);
    chk(clock_released === 1'b1, "no fallback clock");
    chk(oscillator_control_register[6] === 1'b1, "fail bit");
    end_of_test();
  end
endmodule // reset_delay_sequencer_bench
`default_nettype wire
